// >>> asld_map.vh
// Purpose: Constants for the activation status indicator driver.
// Assumes: 100 MHz system clock.
// Notes: Pattern codes select one of four indicator patterns.
`ifndef ASLD_MAP_VH
`define ASLD_MAP_VH
`define ASLD_CLK_HZ 100000000
`define ASLD_FAST_HZ 8
`define ASLD_SLOW_HZ 1
`define ASLD_FAST_HALF (`ASLD_CLK_HZ / (2 * `ASLD_FAST_HZ))
`define ASLD_SLOW_HALF (`ASLD_CLK_HZ / (2 * `ASLD_SLOW_HZ))
`define ASLD_PAT_OFF 2'h0
`define ASLD_PAT_FAST 2'h1
`define ASLD_PAT_SLOW 2'h2
`define ASLD_PAT_ON 2'h3
`define ASLD_U_DEACT 4'h0
`define ASLD_U_AWAKED 4'h1
`define ASLD_U_SYNC1 4'h2
`define ASLD_U_SYNC2 4'h3
`define ASLD_U_WAIT_UP 4'h4
`define ASLD_U_TRANSP 4'h5
`define ASLD_U_ERR_S 4'h6
`define ASLD_U_PEND_S 4'h7
`define ASLD_U_PEND_U 4'h8
`define ASLD_S_ACTIVATED 4'h7
`define ASLD_CNT_RST 27'h0000000
`define ASLD_PH_RST 1'b0
`define ASLD_LIT_RST 1'b0
`endif

// >>> asld_top.v
// Purpose: Drive the open-drain activation status indicator.
// Assumes: State codes arrive synchronous to CLK_IN.
// Notes: The pin is open drain; low means lit.
`timescale 1ns/1ns
`include "asld_map.vh"

// Summary of operation
// - Auto: off, 8Hz, 1Hz, on by status.
// - Software picks pattern through two control bits.
// - U deactivated, plus awakened if simplified machine.
// - U activated in sync through pending deactivation states.
// - S activated only in its activated state.
// - One configuration bit selects automatic or software.
module asld_top
#(
	parameter FAST_HALF = `ASLD_FAST_HALF,
	parameter SLOW_HALF = `ASLD_SLOW_HALF
)
(
	// Clock and reset.
	input wire CLK_IN,
	input wire RST_IN,
	// Transceiver status.
	input wire [3:0] U_STATE_IN,
	input wire U_SIMPLIFIED_IN,
	input wire [3:0] S_STATE_IN,
	// Control bits.
	input wire SECOND_MODE_CONFIG_IN,
	input wire INDICATOR_PATTERN_BIT_A_IN,
	input wire INDICATOR_PATTERN_BIT_B_IN,
	// Indicator pin.
	output wire STATUS_INDICATOR_OUT,
	output wire STATUS_INDICATOR_OE_OUT
);

////////////////////////////////////////////////////////////////////////////////
// Unknown U codes count as neither deactivated nor activated, so they flash fast.
function u_is_down;
	input [3:0] st;
	input simple;
	begin
		case (st)
			`ASLD_U_DEACT:
				u_is_down = 1'b1;
			`ASLD_U_AWAKED:
				if (simple)
					u_is_down = 1'b1;
				else
					u_is_down = 1'b0;
			default:
				u_is_down = 1'b0;
		endcase
	end
endfunction

function u_is_up;
	input [3:0] st;
	begin
		case (st)
			`ASLD_U_SYNC1:
				u_is_up = 1'b1;
			`ASLD_U_SYNC2:
				u_is_up = 1'b1;
			`ASLD_U_WAIT_UP:
				u_is_up = 1'b1;
			`ASLD_U_TRANSP:
				u_is_up = 1'b1;
			`ASLD_U_ERR_S:
				u_is_up = 1'b1;
			`ASLD_U_PEND_S:
				u_is_up = 1'b1;
			`ASLD_U_PEND_U:
				u_is_up = 1'b1;
			default:
				u_is_up = 1'b0;
		endcase
	end
endfunction

function s_is_up;
	input [3:0] st;
	begin
		if (st == `ASLD_S_ACTIVATED)
			s_is_up = 1'b1;
		else
			s_is_up = 1'b0;
	end
endfunction

function [1:0] auto_code;
	input down;
	input up;
	input s_up;
	begin
		if (down)
			auto_code = `ASLD_PAT_OFF;
		else if (!up)
			auto_code = `ASLD_PAT_FAST;
		else if (!s_up)
			auto_code = `ASLD_PAT_SLOW;
		else
			auto_code = `ASLD_PAT_ON;
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Pattern selection.
wire u_down;
wire u_up;
wire s_up;
reg [1:0] auto_pat;
reg [1:0] soft_pat;
reg [1:0] pat;

assign u_down = u_is_down(U_STATE_IN, U_SIMPLIFIED_IN);
assign u_up = u_is_up(U_STATE_IN);
assign s_up = s_is_up(S_STATE_IN);

always @*
begin
	auto_pat = auto_code(u_down, u_up, s_up);
	soft_pat = {INDICATOR_PATTERN_BIT_B_IN, INDICATOR_PATTERN_BIT_A_IN};
	// The mode bit is an unregistered input; reset does not force automatic mode.
	if (SECOND_MODE_CONFIG_IN)
		pat = soft_pat;
	else
		pat = auto_pat;
end

////////////////////////////////////////////////////////////////////////////////
// Free-running dividers; phase is not aligned to pattern changes, which only
// costs at most one half period of visible jitter.
// Each divider raises a one-cycle tick at the end of its half period.
localparam DIV_FAST = 0;
localparam DIV_SLOW = 1;
wire [1:0] div_tick;
wire [1:0] div_ph;
genvar gi;

generate
	for (gi = 0; gi < 2; gi = gi + 1)
	begin : g_div
		localparam [31:0] HALF_LAST = (gi == DIV_FAST) ? FAST_HALF - 1 : SLOW_HALF - 1;
		reg [26:0] cnt_q;
		reg [26:0] cnt_d;
		reg ph_q;
		reg ph_d;

		assign div_tick[gi] = ({5'h00, cnt_q} == HALF_LAST);
		assign div_ph[gi] = ph_q;

		always @*
		begin
			if (div_tick[gi])
			begin
				cnt_d = `ASLD_CNT_RST;
				ph_d = ~ph_q;
			end
			else
			begin
				cnt_d = cnt_q + 27'h0000001;
				ph_d = ph_q;
			end
		end

		always @(posedge CLK_IN)
		begin
			if (RST_IN)
			begin
				cnt_q <= `ASLD_CNT_RST;
				ph_q <= `ASLD_PH_RST;
			end
			else
			begin
				cnt_q <= cnt_d;
				ph_q <= ph_d;
			end
		end
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Registering the output keeps decode glitches off the indicator pin.
reg lit_d;
reg lit_q;

// Codes outside the four patterns cannot occur; the default keeps the pin dark.
always @*
begin
	case (pat)
		`ASLD_PAT_OFF:
			lit_d = 1'b0;
		`ASLD_PAT_FAST:
			lit_d = div_ph[DIV_FAST];
		`ASLD_PAT_SLOW:
			lit_d = div_ph[DIV_SLOW];
		`ASLD_PAT_ON:
			lit_d = 1'b1;
		default:
			lit_d = 1'b0;
	endcase
end

always @(posedge CLK_IN)
begin
	if (RST_IN)
	begin
		lit_q <= `ASLD_LIT_RST;
	end
	else
	begin
		lit_q <= lit_d;
	end
end

// Open drain: pull low while lit, release otherwise.
assign STATUS_INDICATOR_OUT = 1'b0;
assign STATUS_INDICATOR_OE_OUT = lit_q;

endmodule // asld_top

// >>> asld_led.sv
// Purpose: LED on the pulled-up indicator pin. Assumes: Pull-up. Notes: Lit when low.
`timescale 1ns/1ns
module asld_led(input wire D_IN, input wire OE_IN, output wire LIT_OUT);
	// A released pin floats to the pull-up, so only a driven low lights it.
	assign LIT_OUT = OE_IN & !D_IN;
endmodule // asld_led

// >>> asld_properties.sv
// Purpose: Indicator checks. Assumes: One clock. Notes: Bound at the foot.
`timescale 1ns/1ns
module asld_properties(input wire CLK_IN, RST_IN, U_SIMPLIFIED_IN, SECOND_MODE_CONFIG_IN,
	INDICATOR_PATTERN_BIT_A_IN, INDICATOR_PATTERN_BIT_B_IN, STATUS_INDICATOR_OUT,
	STATUS_INDICATOR_OE_OUT, input wire [3:0] U_STATE_IN, S_STATE_IN);
	wire [3:0] u = U_STATE_IN;
	wire o = STATUS_INDICATOR_OE_OUT;
	wire [1:0] p = SECOND_MODE_CONFIG_IN ? {INDICATOR_PATTERN_BIT_B_IN, INDICATOR_PATTERN_BIT_A_IN}
		: u < 4'h2 && (!u || U_SIMPLIFIED_IN) ? 2'h0 : u < 4'h2 || u > 4'h8 ? 2'h1
		: S_STATE_IN == 4'h7 ? 2'h3 : 2'h2;
	default clocking k @(posedge CLK_IN);
	endclocking
	default disable iff (RST_IN);
	chk_off_lvl: assert property(p == 0 |=> !o) else $error("off");
	chk_on_lvl: assert property(p == 3 |=> o) else $error("on");
	chk_soft_off: assert property(SECOND_MODE_CONFIG_IN && !p |=> !o) else $error("soft");
	chk_data_low: assert property(!STATUS_INDICATOR_OUT) else $error("data");
	chk_rst_dark: assert property($fell(RST_IN) |-> !o) else $error("rst");
	chk_fast_rate: assert property(not (p == 1 && $stable(o))[*8]) else $error("fast");
	chk_slow_rate: assert property($past(p, 2) == 2 && $past(p) == 2 && $changed(o)
		|=> ($past(p, 2) != 2 || $past(p) != 2 || $stable(o))[*8]) else $error("slow");
endmodule // asld_properties
bind asld_top asld_properties chk(.*);

// >>> testbench.sv
// Purpose: Random indicator bench. Assumes: Halves 4 and 16. Notes: Counts LED toggles.
`timescale 1ns/1ns
module testbench;
	reg CLK_IN = 0, RST_IN = 1, m = 0, a = 0, b = 0, h = 0;
	reg [3:0] u = 0, s = 0, x;
	reg [31:0] r = 32'h5BEDD916;
	reg [1:0] q[$];
	integer bad_count = 0, num_checks = 0, c = 0, t = 0;
	wire o, oe, lit;
	asld_top #(4, 16) DUT(.CLK_IN(CLK_IN), .RST_IN(RST_IN), .U_STATE_IN(u), .U_SIMPLIFIED_IN(h),
		.S_STATE_IN(s), .SECOND_MODE_CONFIG_IN(m), .INDICATOR_PATTERN_BIT_A_IN(a),
		.INDICATOR_PATTERN_BIT_B_IN(b), .STATUS_INDICATOR_OUT(o), .STATUS_INDICATOR_OE_OUT(oe));
	asld_led LED(.D_IN(o), .OE_IN(oe), .LIT_OUT(lit));
	function [31:0] nx(input [31:0] v);
		nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task summarize;
	begin
		bad_count += t > 9000;
		$display("checks %0d bad %0d", num_checks, bad_count);
		if (!bad_count && num_checks) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	end
	endtask
	initial forever #5 CLK_IN = ~CLK_IN;
	always @(lit) c++;
	always @(posedge CLK_IN) if (++t > 9000) summarize;
	initial
	begin
		repeat (3) @(posedge CLK_IN);
		RST_IN <= 0;
		repeat (48)
		begin
			@(posedge CLK_IN);
			r = nx(r);
			x = r[17] ? r[3:0] & 4'h1 : r[3:0];
			{u, m, b, a, h} <= {x, r[12] & r[13], r[16:14]};
			s <= r[7] ? 4'h7 : r[11:8];
			q.push_back(r[12] & r[13] ? r[16:15] : x < 4'h2 && (!x || r[14]) ? 2'h0 :
				x < 4'h2 || x > 4'h8 ? 2'h1 : r[7] || r[11:8] == 4'h7 ? 2'h3 : 2'h2);
			wait (!q.size());
		end
		summarize;
	end
	// Toggle counts keep the verdict free of the divider's phase.
	initial forever
	begin
		wait (q.size());
		repeat (3) @(posedge CLK_IN);
		c = 0;
		repeat (64) @(posedge CLK_IN);
		num_checks++;
		if ((c ? c > 8 ? 2'h1 : 2'h2 : {lit, lit}) !== q[0])
		begin
			bad_count++;
			$display("MISMATCH %0t pattern", $time);
		end
		q.pop_front();
	end
endmodule // testbench
